// *** src/piv_ctrl.sv ***
// Overview of operation
// - Two priority bits per source, four levels
// - Only strictly higher level preempts running routine
// - Top-level routine is never preempted
// - Higher level wins among simultaneous requests
// - Equal level ties go to lowest index
// - Index order breaks ties only
// - Sample at fetch, evaluate in last instruction cycle
// - Block while equal or higher level active
// - Vector only in final instruction cycle
// - After return or enable writes, one more instruction
// - Block during flash self programming
// - Blocked requests are not remembered
// - Poll in last cycle of every instruction
// - Issue long call, no status word saved
// - Vector 0003h plus eight per index
// - Serial flags are never cleared here
// - Vectoring clears external flag if edge mode
// - Interrupt return clears top in-progress level
// - Plain return leaves in-progress state alone
// - Level mode follows pin, edge mode latches
// - Global enable gates every source
// - Hardware call takes six clocks
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "piv_map.svh"

module piv_ctrl (
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_b_in,
   // AHB-Lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   // External request pins, active low
   input  wire logic [1:0]  ext_request_pin_n_in,
   // Peripheral request flags
   input  wire logic        timer0_overflow_flag_in,
   input  wire logic        timer1_overflow_flag_in,
   input  wire logic        serial_rx_flag_in,
   input  wire logic        serial_tx_flag_in,
   input  wire logic        converter_done_flag_in,
   input  wire logic        low_voltage_flag_in,
   input  wire logic        counter_array_flag_in,
   input  wire logic        serial2_rx_flag_in,
   input  wire logic        serial2_tx_flag_in,
   input  wire logic        serial_periph_done_flag_in,
   // Instruction sequencer status
   input  wire logic        opcode_fetch_in,
   input  wire logic        instr_last_cycle_in,
   input  wire logic        return_from_interrupt_instr_in,
   input  wire logic        flash_self_programming_in,
   // Call request to the sequencer
   output logic             long_call_req_out,
   output logic      [15:0] long_call_vector_out,
   output logic      [3:0]  long_call_index_out,
   output logic             long_call_busy_out,
   output logic      [3:0]  level_in_progress_out
);
   import piv_pkg::*;

   piv_state_t st_ff;
   piv_state_t nxt_st;

   // ---------------------------------------------
   // Combinational helpers
   // ---------------------------------------------
   logic       addr_ph;
   logic       wr_now;
   logic       ctl_wr;
   piv_src_t   raw_req;
   piv_src_t   elig;
   logic       found;
   logic [3:0] best_idx;
   piv_level_t best_lvl;
   piv_level_t lvl_i;
   logic       lvl_blk;
   logic       poll_blk;
   logic       take;
   logic [3:0] top_lvl;
   logic       top_any;
   logic [1:0] edge_set;
   logic [1:0] flag_clr;

   always_comb begin
      nxt_st = st_ff;
      found = 1'b0;
      best_idx = 4'h0;
      best_lvl = 2'h0;
      lvl_i = 2'h0;
      lvl_blk = 1'b0;
      top_lvl = 4'h0;
      top_any = 1'b0;
      flag_clr = 2'h0;

      // ---------------------------------------------
      // Bus decode
      // ---------------------------------------------
      addr_ph = hsel_in & htrans_in[1] & hready_in;
      wr_now = st_ff.dp_wr;
      // Enable and priority writes hold off vectoring,
      // just as an interrupt return does
      ctl_wr = wr_now &&
               (st_ff.dp_addr == `PIV_OFS_ENABLE ||
                st_ff.dp_addr == `PIV_OFS_PRIO_LO ||
                st_ff.dp_addr == `PIV_OFS_PRIO_HI);

      // ---------------------------------------------
      // External request pins
      // ---------------------------------------------
      nxt_st.pin_s1 = ext_request_pin_n_in;
      nxt_st.pin_s2 = st_ff.pin_s1;
      nxt_st.pin_prev = st_ff.pin_s2;
      edge_set = st_ff.pin_prev & ~st_ff.pin_s2;

      // ---------------------------------------------
      // Request sampling at opcode fetch
      // ---------------------------------------------
      // Bit order is the fixed polling order, index 0 at the bottom
      raw_req = {serial_periph_done_flag_in,
                 serial2_rx_flag_in | serial2_tx_flag_in,
                 counter_array_flag_in,
                 low_voltage_flag_in,
                 converter_done_flag_in,
                 serial_rx_flag_in | serial_tx_flag_in,
                 timer1_overflow_flag_in,
                 st_ff.ext_flag[1],
                 timer0_overflow_flag_in,
                 st_ff.ext_flag[0]};
      if (opcode_fetch_in) begin
         nxt_st.smp = raw_req;
      end

      // ---------------------------------------------
      // Arbitration
      // ---------------------------------------------
      // global and source enables
      elig = st_ff.smp & st_ff.en & {10{st_ff.gen}};
      for (int i = 0; i < 10; i++) begin
         lvl_i = {st_ff.phi[i], st_ff.plo[i]};
         if (elig[i] && (!found || lvl_i > best_lvl)) begin
            found = 1'b1;
            best_idx = 4'(i);
            best_lvl = lvl_i;
         end
      end
      // Any active level at or above the winner blocks it
      for (int j = 0; j < 4; j++) begin
         if (st_ff.inprog[j] && 2'(j) >= best_lvl) begin
            lvl_blk = 1'b1;
         end
      end
      poll_blk = lvl_blk | st_ff.hold | ctl_wr |
                 return_from_interrupt_instr_in |
                 flash_self_programming_in |
                 st_ff.call_busy;
      take = instr_last_cycle_in & found & ~poll_blk;

      // ---------------------------------------------
      // Blocking after return or control write
      // ---------------------------------------------
      // A block raised mid-instruction is kept until the last cycle,
      // so that poll is refused and one more instruction runs
      if (instr_last_cycle_in) begin
         nxt_st.hold = 1'b0;
      end else if (ctl_wr || return_from_interrupt_instr_in) begin
         nxt_st.hold = 1'b1;
      end

      // ---------------------------------------------
      // Hardware call
      // ---------------------------------------------
      nxt_st.ack = 1'b0;
      if (st_ff.call_cnt != 3'h0) begin
         nxt_st.call_cnt = st_ff.call_cnt - 3'h1;
      end
      if (take) begin
         // long call request, no status save
         nxt_st.ack = 1'b1;
         nxt_st.vidx = best_idx;
         nxt_st.vec = `PIV_VEC_BASE +
                      16'({best_idx, 3'h0});
         nxt_st.call_cnt = `PIV_CALL_CYCLES;
         nxt_st.inprog[best_lvl] = 1'b1;
         if (best_idx == 4'(`PIV_IDX_EXT0)) begin
            flag_clr[0] = st_ff.ext_type[0];
         end
         if (best_idx == 4'(`PIV_IDX_EXT1)) begin
            flag_clr[1] = st_ff.ext_type[1];
         end
      end
      // Busy covers the whole forced call so that no second call
      // starts before the sequencer has finished the first
      nxt_st.call_busy = (nxt_st.call_cnt != 3'h0);

      // ---------------------------------------------
      // Interrupt return
      // ---------------------------------------------
      // Highest level still marked active
      for (int j = 0; j < 4; j++) begin
         if (st_ff.inprog[j]) begin
            top_lvl = 4'(j);
            top_any = 1'b1;
         end
      end
      // plain return has no input here
      if (instr_last_cycle_in && return_from_interrupt_instr_in &&
          top_any) begin
         nxt_st.inprog[top_lvl[1:0]] = 1'b0;
      end

      // ---------------------------------------------
      // Register writes
      // ---------------------------------------------
      if (wr_now) begin
         case (st_ff.dp_addr)
            `PIV_OFS_ENABLE: begin
               nxt_st.en = hwdata_in[9:0];
               nxt_st.gen = hwdata_in[`PIV_BIT_GLOBAL];
            end
            `PIV_OFS_PRIO_LO: begin
               nxt_st.plo = hwdata_in[9:0];
            end
            `PIV_OFS_PRIO_HI: begin
               nxt_st.phi = hwdata_in[9:0];
            end
            `PIV_OFS_EXTCTL: begin
               nxt_st.ext_type[0] = hwdata_in[`PIV_BIT_TYPE0];
               nxt_st.ext_type[1] = hwdata_in[`PIV_BIT_TYPE1];
               nxt_st.ext_flag[0] = hwdata_in[`PIV_BIT_FLAG0];
               nxt_st.ext_flag[1] = hwdata_in[`PIV_BIT_FLAG1];
            end
            default: begin
            end
         endcase
      end

      // ---------------------------------------------
      // External request flags
      // ---------------------------------------------
      // Edge set beats the vector clear, which beats a software write
      for (int k = 0; k < 2; k++) begin
         if (!st_ff.ext_type[k]) begin
            nxt_st.ext_flag[k] = ~st_ff.pin_s2[k];
         end else if (edge_set[k]) begin
            nxt_st.ext_flag[k] = 1'b1;
         end else if (flag_clr[k]) begin
            nxt_st.ext_flag[k] = 1'b0;
         end
      end

      // ---------------------------------------------
      // Bus address phase and read data
      // ---------------------------------------------
      // Zero wait states: read data is fetched in the address phase
      // and stands for the data phase only
      nxt_st.hready = 1'b1;
      nxt_st.dp_wr = addr_ph & hwrite_in;
      nxt_st.dp_addr = haddr_in[7:0];
      nxt_st.hrdata = 32'h0000_0000;
      if (addr_ph && !hwrite_in) begin
         case (haddr_in[7:0])
            `PIV_OFS_ENABLE: begin
               nxt_st.hrdata[9:0] = st_ff.en;
               nxt_st.hrdata[`PIV_BIT_GLOBAL] = st_ff.gen;
            end
            `PIV_OFS_PRIO_LO: begin
               nxt_st.hrdata[9:0] = st_ff.plo;
            end
            `PIV_OFS_PRIO_HI: begin
               nxt_st.hrdata[9:0] = st_ff.phi;
            end
            `PIV_OFS_EXTCTL: begin
               nxt_st.hrdata[`PIV_BIT_TYPE0] = st_ff.ext_type[0];
               nxt_st.hrdata[`PIV_BIT_TYPE1] = st_ff.ext_type[1];
               nxt_st.hrdata[`PIV_BIT_FLAG0] = st_ff.ext_flag[0];
               nxt_st.hrdata[`PIV_BIT_FLAG1] = st_ff.ext_flag[1];
            end
            `PIV_OFS_STATUS: begin
               nxt_st.hrdata[3:0] = st_ff.inprog;
               nxt_st.hrdata[7:4] = st_ff.vidx;
               nxt_st.hrdata[8] = st_ff.call_busy;
               nxt_st.hrdata[9] = st_ff.hold;
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_ff.en <= `PIV_RST_SRC;
         st_ff.gen <= 1'b0;
         st_ff.plo <= `PIV_RST_SRC;
         st_ff.phi <= `PIV_RST_SRC;
         st_ff.ext_type <= `PIV_RST_EXT;
         st_ff.ext_flag <= `PIV_RST_EXT;
         // Synchroniser starts at the idle high level, so no false edge
         st_ff.pin_s1 <= 2'h3;
         st_ff.pin_s2 <= 2'h3;
         st_ff.pin_prev <= 2'h3;
         st_ff.smp <= `PIV_RST_SRC;
         st_ff.inprog <= 4'h0;
         st_ff.hold <= 1'b0;
         st_ff.call_cnt <= 3'h0;
         st_ff.call_busy <= 1'b0;
         st_ff.ack <= 1'b0;
         st_ff.vidx <= 4'h0;
         st_ff.vec <= 16'h0000;
         st_ff.dp_wr <= 1'b0;
         st_ff.dp_addr <= 8'h00;
         st_ff.hrdata <= 32'h0000_0000;
         st_ff.hready <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign hrdata_out = st_ff.hrdata;
   assign hreadyout_out = st_ff.hready;
   // Every transfer ends OKAY
   assign hresp_out = 1'b0;
   assign long_call_req_out = st_ff.ack;
   assign long_call_vector_out = st_ff.vec;
   assign long_call_index_out = st_ff.vidx;
   assign long_call_busy_out = st_ff.call_busy;
   assign level_in_progress_out = st_ff.inprog;

   // Unused bus qualifiers
   logic unused_ok;
   assign unused_ok = ^{hsize_in, haddr_in[31:8], htrans_in[0]};

endmodule : piv_ctrl

`default_nettype wire

// *** src/piv_map.svh ***
`ifndef PIV_MAP_SVH
`define PIV_MAP_SVH
// Register byte offsets
`define PIV_OFS_ENABLE   8'h00
`define PIV_OFS_PRIO_LO  8'h04
`define PIV_OFS_PRIO_HI  8'h08
`define PIV_OFS_EXTCTL   8'h0c
`define PIV_OFS_STATUS   8'h10
// Field positions
`define PIV_BIT_GLOBAL   15
`define PIV_BIT_TYPE0    0
`define PIV_BIT_TYPE1    1
`define PIV_BIT_FLAG0    2
`define PIV_BIT_FLAG1    3
`define PIV_IDX_EXT0     0
`define PIV_IDX_EXT1     2
// Reset values
`define PIV_RST_SRC      10'h000
`define PIV_RST_EXT      2'h0
// Vector table and call timing
`define PIV_VEC_BASE     16'h0003
`define PIV_VEC_SHIFT    3
`define PIV_CALL_CYCLES  3'h6
`endif

// *** src/piv_pkg.sv ***
`default_nettype none
package piv_pkg;
   typedef logic [1:0] piv_level_t;
   typedef logic [9:0] piv_src_t;

   typedef struct packed {
      piv_src_t    en;
      logic        gen;
      piv_src_t    plo;
      piv_src_t    phi;
      logic [1:0]  ext_type;
      logic [1:0]  ext_flag;
      logic [1:0]  pin_s1;
      logic [1:0]  pin_s2;
      logic [1:0]  pin_prev;
      piv_src_t    smp;
      logic [3:0]  inprog;
      logic        hold;
      logic [2:0]  call_cnt;
      logic        call_busy;
      logic        ack;
      logic [3:0]  vidx;
      logic [15:0] vec;
      logic        dp_wr;
      logic [7:0]  dp_addr;
      logic [31:0] hrdata;
      logic        hready;
   } piv_state_t;
endpackage : piv_pkg
`default_nettype wire

// *** tb/piv_ctrl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module piv_ctrl_props (
   // Clock and reset
   input wire logic        core_clk_in,
   input wire logic        rst_b_in,
   // Sequencer status
   input wire logic        instr_last_cycle_in,
   input wire logic        return_from_interrupt_instr_in,
   input wire logic        flash_self_programming_in,
   // Call outputs
   input wire logic        long_call_req_out,
   input wire logic [15:0] long_call_vector_out,
   input wire logic [3:0]  long_call_index_out,
   input wire logic        long_call_busy_out,
   input wire logic [3:0]  level_in_progress_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);
   property p_busy;
      long_call_req_out |-> long_call_busy_out [*6] ##1 !long_call_busy_out;
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy span wrong");
   property p_one;
      long_call_req_out |=> !long_call_req_out;
   endproperty
   a_one: assert property (p_one)
      else $error("call pulse too long");
   property p_final;
      long_call_req_out |-> $past(instr_last_cycle_in);
   endproperty
   a_final: assert property (p_final)
      else $error("call outside last cycle");
   property p_flash;
      long_call_req_out |-> !$past(flash_self_programming_in);
   endproperty
   a_flash: assert property (p_flash)
      else $error("call during flash write");
   property p_vec;
      long_call_req_out |-> long_call_index_out <= 4'h9 &&
         long_call_vector_out == 16'h0003 + {9'h0, long_call_index_out, 3'h0};
   endproperty
   a_vec: assert property (p_vec)
      else $error("vector wrong");
   property p_lvl;
      long_call_req_out |->
         $onehot(level_in_progress_out ^ $past(level_in_progress_out)) &&
         level_in_progress_out > {$past(level_in_progress_out), 1'b0};
   endproperty
   a_lvl: assert property (p_lvl)
      else $error("call not above active levels");
   property p_top;
      $past(level_in_progress_out[3]) |-> !long_call_req_out;
   endproperty
   a_top: assert property (p_top)
      else $error("top level preempted");
   property p_ret;
      return_from_interrupt_instr_in && instr_last_cycle_in &&
         level_in_progress_out != 4'h0 |=> !long_call_req_out &&
         $onehot($past(level_in_progress_out) ^ level_in_progress_out) &&
         ($past(level_in_progress_out) ^ level_in_progress_out) >
         level_in_progress_out;
   endproperty
   a_ret: assert property (p_ret)
      else $error("return level wrong");
endmodule : piv_ctrl_props
bind piv_ctrl piv_ctrl_props piv_ctrl_props_i (
   .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
   .instr_last_cycle_in(instr_last_cycle_in),
   .return_from_interrupt_instr_in(return_from_interrupt_instr_in),
   .flash_self_programming_in(flash_self_programming_in),
   .long_call_req_out(long_call_req_out),
   .long_call_vector_out(long_call_vector_out),
   .long_call_index_out(long_call_index_out),
   .long_call_busy_out(long_call_busy_out),
   .level_in_progress_out(level_in_progress_out));
`default_nettype wire

// *** tb/piv_seq_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module piv_seq_model #(parameter int LEN = 3) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   // Bench control
   input  wire logic return_from_interrupt_instr_req_in,
   // Sequencer status
   output logic      fetch_out,
   output logic      last_out,
   output logic      return_from_interrupt_instr_out
);
   // ----
   // Fixed length instructions, fetch first, poll last
   // ----
   logic [1:0] cnt_ff;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         cnt_ff <= 2'h0;
      else if (cnt_ff == LEN - 1)
         cnt_ff <= 2'h0;
      else
         cnt_ff <= cnt_ff + 2'h1;
   end
   assign fetch_out = (cnt_ff == 2'h0);
   assign last_out  = (cnt_ff == LEN - 1);
   assign return_from_interrupt_instr_out  = return_from_interrupt_instr_req_in & last_out;
endmodule : piv_seq_model
`default_nettype wire

// *** tb/test_priority_interrupt_vectoring.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_priority_interrupt_vectoring;
   logic        clk, rst_b, hsel, hwrite, txf, flash, do_return_from_interrupt_instr;
   logic [31:0] haddr, hwdata, hrdata, rd_v;
   logic [1:0]  htrans, pin;
   logic [9:0]  src;
   logic [15:0] vec;
   logic [3:0]  idx, lvl;
   logic        hrdy, hresp, fetch, last, rti, req, busy;
   int          mismatches, n_compared;
   piv_ctrl piv_ctrl_i (.core_clk_in(clk), .rst_b_in(rst_b),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
      .hresp_out(hresp), .ext_request_pin_n_in(pin),
      .timer0_overflow_flag_in(src[1]), .timer1_overflow_flag_in(src[3]),
      .serial_rx_flag_in(src[4]), .serial_tx_flag_in(txf),
      .converter_done_flag_in(src[5]), .low_voltage_flag_in(src[6]),
      .counter_array_flag_in(src[7]), .serial2_rx_flag_in(src[8]),
      .serial2_tx_flag_in(txf), .serial_periph_done_flag_in(src[9]),
      .opcode_fetch_in(fetch), .instr_last_cycle_in(last),
      .return_from_interrupt_instr_in(rti),
      .flash_self_programming_in(flash), .long_call_req_out(req),
      .long_call_vector_out(vec), .long_call_index_out(idx),
      .long_call_busy_out(busy), .level_in_progress_out(lvl));
   piv_seq_model piv_seq_model_i (.clk_in(clk), .rst_b_in(rst_b),
      .return_from_interrupt_instr_req_in(do_return_from_interrupt_instr), .fetch_out(fetch), .last_out(last),
      .return_from_interrupt_instr_out(rti));
   // ----
   // Shared tasks
   // ----
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd_v = hrdata;
   endtask : bus
   task call(input logic [3:0] i, input logic [3:0] l);
      int k;
      k = 0;
      while (req !== 1'b1 && k < 60) begin
         @(posedge clk);
         k++;
      end
      chk(k < 60, 1);
      chk(idx, i);
      chk(vec, 16'h0003 + {9'h0, i, 3'h0});
      chk(lvl, l);
      @(posedge clk);
   endtask : call
   task quiet(input int n);
      int c;
      c = 0;
      repeat (n) begin
         @(posedge clk);
         if (req !== 1'b0) c++;
      end
      chk(c, 0);
   endtask : quiet
   task ret(input logic [3:0] l);
      do_return_from_interrupt_instr <= 1'b1;
      do @(posedge clk); while (rti !== 1'b1);
      do_return_from_interrupt_instr <= 1'b0;
      @(posedge clk);
      chk(lvl, l);
   endtask : ret
   // ----
   // Scenarios
   // ----
   task t_reset;
      chk({hrdy, hresp, req, busy, lvl}, 8'h80);
      bus(0, 8'h10, 0);
      chk(rd_v, 0);
      bus(1, 8'h20, 32'hffff);
      bus(0, 8'h20, 0);
      chk(rd_v, 0);
      bus(1, 8'h04, 32'h3ff);
      bus(0, 8'h04, 0);
      chk(rd_v, 32'h3ff);
      bus(1, 8'h04, 0);
      bus(1, 8'h00, 32'h83ff);
      bus(0, 8'h00, 0);
      chk(rd_v, 32'h83ff);
   endtask : t_reset
   task t_order;
      for (int i = 0; i < 10; i++) begin
         if (i == 0 || i == 2) pin[i / 2] <= 1'b0;
         else src[i] <= 1'b1;
         call(i[3:0], 4'h1);
         repeat (12) @(posedge clk);
         pin <= 2'h3;
         src <= 10'h0;
         repeat (4) @(posedge clk);
         ret(4'h0);
         quiet(12);
      end
      txf <= 1'b1;
      call(4'h4, 4'h1);
      txf <= 1'b0;
      ret(4'h0);
      quiet(12);
   endtask : t_order
   task t_prio;
      bus(1, 8'h04, 32'h28);
      bus(1, 8'h08, 32'h20);
      src <= 10'h022;
      call(4'h5, 4'h8);
      src[5] <= 1'b0;
      quiet(30);
      ret(4'h0);
      call(4'h1, 4'h1);
      src[3] <= 1'b1;
      call(4'h3, 4'h3);
      src[3] <= 1'b0;
      quiet(30);
      src[1] <= 1'b0;
      ret(4'h1);
      ret(4'h0);
      bus(1, 8'h04, 0);
      bus(1, 8'h08, 0);
   endtask : t_prio
   task t_block;
      bus(1, 8'h00, 32'h3ff);
      src[1] <= 1'b1;
      quiet(30);
      flash <= 1'b1;
      bus(1, 8'h00, 32'h83ff);
      quiet(30);
      src[1] <= 1'b0;
      repeat (6) @(posedge clk);
      flash <= 1'b0;
      quiet(30);
   endtask : t_block
   task t_edge;
      bus(1, 8'h0c, 32'h1);
      repeat (12) @(posedge clk);
      pin[0] <= 1'b0;
      call(4'h0, 4'h1);
      bus(0, 8'h0c, 0);
      chk(rd_v, 32'h1);
      ret(4'h0);
      quiet(30);
      pin[0] <= 1'b1;
   endtask : t_edge
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      {rst_b, hsel, hwrite, txf, flash, do_return_from_interrupt_instr} = 6'h0;
      {haddr, hwdata, htrans, src} = 76'h0;
      pin = 2'h3;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_order;
      t_prio;
      t_block;
      t_edge;
      print_verdict;
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      print_verdict;
   end
endmodule : test_priority_interrupt_vectoring
`default_nettype wire
